// File: pdor_regs.vh
`ifndef PDOR_REGS_VH
`define PDOR_REGS_VH
// ==========================================================
// Register map, offsets within one group
`define PDOR_OFS_PIN_DIRECTION 7'h00
`define PDOR_OFS_DIRECTION_CLEAR 7'h04
`define PDOR_OFS_DIRECTION_SET 7'h08
`define PDOR_OFS_DIRECTION_TOGGLE 7'h0c
`define PDOR_OFS_OUTPUT_LEVEL 7'h10
`define PDOR_GROUP_STRIDE 7'h80
`define PDOR_GROUP_SHIFT 7
`define PDOR_RESET_VAL 32'h00000000
// ==========================================================
// AXI response codes
`define PDOR_RESP_OKAY 2'h0
`define PDOR_RESP_SLVERR 2'h2
`endif

// File: pdor_group.v
`timescale 1ns/100ps
`include "pdor_regs.vh"
// ==========================================================
// One pin group: direction word and output level word
module pdor_group #(
  parameter WIDTH = 32
) (
  input wire core_clk,
  input wire rst_sync_n,
  input wire wr_en,
  input wire [2:0] wr_reg,
  input wire [WIDTH-1:0] wr_data,
  input wire [WIDTH-1:0] wr_mask,
  output reg [WIDTH-1:0] pin_direction,
  output reg [WIDTH-1:0] output_level
);
  // Register selects: 0 direction, 1 clear, 2 set, 3 toggle, 4 level
  wire [WIDTH-1:0] ones;
  reg [WIDTH-1:0] next_pin_direction;
  reg [WIDTH-1:0] next_output_level;
  assign ones = wr_data & wr_mask;

  // Alias writes act only on bits written as one in enabled lanes
  always @* begin
    next_pin_direction = pin_direction;
    next_output_level = output_level;
    if (wr_en) begin
      case (wr_reg)
        3'h0: next_pin_direction = (pin_direction & ~wr_mask) |
                                   ones;
        3'h1: next_pin_direction = pin_direction & ~ones;
        3'h2: next_pin_direction = pin_direction | ones;
        3'h3: next_pin_direction = pin_direction ^ ones;
        3'h4: next_output_level = (output_level & ~wr_mask) |
                                  ones;
        default: next_pin_direction = pin_direction;
      endcase
    end
  end

  // Both words clear to zero, so every pin starts as an input
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_direction <= `PDOR_RESET_VAL;
      output_level <= `PDOR_RESET_VAL;
    end else begin
      pin_direction <= next_pin_direction;
      output_level <= next_output_level;
    end
  end
endmodule // pdor_group

// File: pdor_top.v
`timescale 1ns/100ps
`include "pdor_regs.vh"
// ==========================================================
// Port direction and output registers, AXI4-Lite slave
module pdor_top #(
  parameter GROUPS = 3,
  parameter WIDTH = 32,
  parameter ADDR_W = 9
) (
  input wire core_clk,
  input wire rst_n,
  input wire write_guard,
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output wire [GROUPS*WIDTH-1:0] pin_output_enable,
  output wire [GROUPS*WIDTH-1:0] pin_level
);
  // ==========================================================
  // Reset release through two flops
  reg rst_meta_n;
  reg rst_sync_n;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ==========================================================
  // Write channel: address and data latched in either order
  reg aw_held;
  reg w_held;
  reg [ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  wire aw_fire;
  wire w_fire;
  wire wr_go;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign wr_go = aw_held && w_held;

  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= {ADDR_W{1'b0}};
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (aw_fire) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (w_fire) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Write decode; unmapped offsets answer SLVERR
  wire [6:0] wr_ofs;
  wire [ADDR_W-1:0] wr_grp;
  wire wr_mapped;
  wire [2:0] wr_reg;
  wire [31:0] wr_mask;
  assign wr_ofs = aw_addr[`PDOR_GROUP_SHIFT-1:0];
  assign wr_grp = aw_addr >> `PDOR_GROUP_SHIFT;
  assign wr_mapped = (wr_grp < GROUPS) && (wr_ofs[1:0] == 2'h0) &&
                     (wr_ofs <= `PDOR_OFS_OUTPUT_LEVEL);
  assign wr_reg = wr_ofs[4:2];
  // Strobes limit the write to the addressed bytes
  assign wr_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                    {8{w_strb[1]}}, {8{w_strb[0]}}};

  // Protected writes are dropped but still answered OKAY, so software
  // running under the guard does not fault.
  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PDOR_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? `PDOR_RESP_OKAY : `PDOR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Pin groups, one register set each
  wire [GROUPS*WIDTH-1:0] direction_all;
  wire [GROUPS*WIDTH-1:0] out_all;
  genvar g;
  generate
    for (g = 0; g < GROUPS; g = g + 1) begin : grp
      wire sel;
      assign sel = wr_go && wr_mapped && !write_guard &&
                   (wr_grp == g);
      pdor_group #(
        .WIDTH(WIDTH)
      ) u_group (
        .core_clk(core_clk),
        .rst_sync_n(rst_sync_n),
        .wr_en(sel),
        .wr_reg(wr_reg),
        .wr_data(w_data[WIDTH-1:0]),
        .wr_mask(wr_mask[WIDTH-1:0]),
        .pin_direction(direction_all[g*WIDTH +: WIDTH]),
        .output_level(out_all[g*WIDTH +: WIDTH])
      );
    end
  endgenerate

  // Direction bit enables the driver; output bit gives the level,
  // which the pad also uses as pull direction for an input.
  assign pin_output_enable = direction_all;
  assign pin_level = out_all;

  // ==========================================================
  // Read channel: one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;
  wire [6:0] rd_ofs;
  wire [ADDR_W-1:0] rd_grp;
  wire rd_mapped;
  assign rd_ofs = s_axi_araddr[`PDOR_GROUP_SHIFT-1:0];
  assign rd_grp = s_axi_araddr >> `PDOR_GROUP_SHIFT;
  assign rd_mapped = (rd_grp < GROUPS) && (rd_ofs[1:0] == 2'h0) &&
                     (rd_ofs <= `PDOR_OFS_OUTPUT_LEVEL);

  // Read mux: the direction word and its three aliases look the same
  reg [31:0] next_rdata;
  integer i;
  always @* begin
    next_rdata = 32'h00000000;
    for (i = 0; i < GROUPS; i = i + 1) begin
      if (rd_grp == i) begin
        if (rd_ofs == `PDOR_OFS_OUTPUT_LEVEL)
          next_rdata[WIDTH-1:0] = out_all[i*WIDTH +: WIDTH];
        else
          next_rdata[WIDTH-1:0] = direction_all[i*WIDTH +: WIDTH];
      end
    end
    if (!rd_mapped)
      next_rdata = 32'h00000000;
  end

  always @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PDOR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= rd_mapped ? `PDOR_RESP_OKAY : `PDOR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // pdor_top

// File: pdor_chk_properties.sv
`timescale 1ns/100ps
// ==========================================================
// Bus handshake and pin checks at the top ports
module pdor_chk #(
  parameter GROUPS = 3,
  parameter WIDTH = 32
) (
  input wire core_clk,
  input wire rst_n,
  input wire write_guard,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [GROUPS*WIDTH-1:0] pin_output_enable,
  input wire [GROUPS*WIDTH-1:0] pin_level
);
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  rvalid_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid lost");
  read_block_a: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("arready while busy");
  write_block_a: assert property (
    s_axi_bvalid |-> !s_axi_awready) else $error("awready while busy");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("no bvalid");
  // A register may only move at the edge that completes a write
  pins_on_write_a: assert property (
    !$stable(pin_output_enable) || !$stable(pin_level) |-> $rose(s_axi_bvalid))
    else $error("pins moved without a write");
  guard_freeze_a: assert property (
    $past(write_guard) && $past(write_guard, 2) |-> $stable(pin_output_enable)
    && $stable(pin_level)) else $error("guarded write landed");
  cover property (write_guard && $rose(s_axi_bvalid));
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property ($rose(s_axi_rvalid) ##1 $rose(s_axi_bvalid));
endmodule // pdor_chk
bind pdor_top pdor_chk #(.GROUPS(GROUPS), .WIDTH(WIDTH)) u_pdor_chk (.*);

// File: port_direction_output_regs_bench.sv
`timescale 1ns/100ps
`include "pdor_regs.vh"
module port_direction_output_regs_bench;
  logic core_clk = 0, rst_n = 0, write_guard = 0, gv;
  logic [8:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, d, m, exp_direction [4], lvl [4];
  logic [3:0] s_axi_wstrb = 0, s;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [95:0] pin_output_enable, pin_level;
  int fail_count = 0, compares = 0, seed = 58, g, k, r;
  pdor_top u_pdor_top (.*);
  // Free-running core clock, 8 ns
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  // Expected word after a strobed write: plain, clear, set or toggle
  function automatic [31:0] exp_next(input [31:0] o, dv, mk, input int kd);
    case (kd)
      1: exp_next = o & ~(dv & mk);
      2: exp_next = o | (dv & mk);
      3: exp_next = o ^ (dv & mk);
      default: exp_next = (o & ~mk) | (dv & mk);
    endcase
  endfunction
  task automatic chk(input string n, input [31:0] e, input [31:0] v);
    compares++;
    if (v !== e) begin
      $display("Error %s expected %h seen %h", n, e, v);
      fail_count++;
    end
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Both halves of a write offered together, each dropped when taken
  task automatic wr(input [8:0] a, input [31:0] dv, input [3:0] sv,
                    input [1:0] er);
    bit ta, tw, tb, hs;
    s_axi_awaddr <= a;
    s_axi_wdata <= dv;
    s_axi_wstrb <= sv;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    // Sometimes hold off the response, raising bready once it shows
    s_axi_bready <= 1'($random(seed));
    for (int n = 0; n < 40; n++) begin
      @(negedge core_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      hs = tb && s_axi_bready;
      if (hs) chk("bresp", er, s_axi_bresp);
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tb && !hs) s_axi_bready <= 1;
      if (hs) return;
    end
    fail_count++;
    print_verdict();
  endtask
  task automatic rd(input [8:0] a, input [31:0] ed, input [1:0] er);
    bit ta, tr, hs;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    // Sometimes hold off the data, raising rready once it shows
    s_axi_rready <= 1'($random(seed));
    for (int n = 0; n < 40; n++) begin
      @(negedge core_clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      hs = tr && s_axi_rready;
      if (hs) chk("rdata", ed, s_axi_rdata);
      if (hs) chk("rresp", er, s_axi_rresp);
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 0;
      if (tr && !hs) s_axi_rready <= 1;
      if (hs) return;
    end
    fail_count++;
    print_verdict();
  endtask
  // Reset, directed corners, then random traffic over all groups
  initial begin
    for (g = 0; g < 4; g++) begin
      exp_direction[g] = 0;
      lvl[g] = 0;
    end
    repeat (20) @(posedge core_clk);
    rst_n <= 1;
    repeat (3) @(posedge core_clk);
    for (k = 0; k < 5; k++) rd(9'(k * 4 + 256), 0, `PDOR_RESP_OKAY);
    wr(9'h002, 32'hffffffff, 4'hf, `PDOR_RESP_SLVERR);
    for (int i = 0; i < 400; i++) begin
      g = {$random(seed)} % 4;
      k = {$random(seed)} % 6;
      r = {$random(seed)} % 6;
      d = $random(seed);
      s = (i % 3 == 0) ? 4'hf : 4'($random(seed));
      gv = ({$random(seed)} % 6) == 0;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      if (g < 3 && k < 5 && !gv && k == 4) lvl[g] = exp_next(lvl[g], d, m, 0);
      else if (g < 3 && k < 5 && !gv)
        exp_direction[g] = exp_next(exp_direction[g], d, m, k);
      write_guard <= gv;
      wr(9'(g * 128 + k * 4), d, s, (g < 3 && k < 5) ? 2'h0 : 2'h2);
      rd(9'(g * 128 + r * 4), (g > 2 || r > 4) ? 0 : (r == 4) ? lvl[g] :
         exp_direction[g], (g < 3 && r < 5) ? 2'h0 : 2'h2);
      // Every real group each time; group 3 has no pins to look at
      for (int j = 0; j < 3; j++) begin
        chk("oe", exp_direction[j], pin_output_enable[j * 32 +: 32]);
        chk("lvl", lvl[j], pin_level[j * 32 +: 32]);
      end
    end
    print_verdict();
  end
endmodule // port_direction_output_regs_bench
